// ---- rtl/spx_fifo.sv ----
/*
  Transmit buffer FIFO with valid/ready on both sides.
  Assumes DEPTH is a power of two so pointers wrap by themselves.
*/
module spx_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input  wire logic   clock,
  input  wire logic   reset,
  // Streams
  spx_stream_if.snk   push,
  spx_stream_if.src   pop
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } spx_fifo_st_t;

  spx_fifo_st_t q;
  spx_fifo_st_t d;
  logic         do_push;
  logic         do_pop;

  // ==========================================================================
  // Flags and handshakes; full and empty come straight from the count
  assign push.ready = (q.cnt != FULL_CNT);
  assign pop.valid  = (q.cnt != '0);
  assign pop.data   = q.mem[q.rp];
  assign do_push    = push.valid && push.ready;
  assign do_pop     = pop.valid && pop.ready;

  // Pointer and count update
  always_comb begin
    d = q;
    if (do_push) begin
      d.mem[q.wp] = push.data;
      d.wp        = q.wp + AW'(1);
    end
    if (do_pop) begin
      d.rp = q.rp + AW'(1);
    end
    if (do_push && !do_pop) begin
      d.cnt = q.cnt + (AW+1)'(1);
    end else if (do_pop && !do_push) begin
      d.cnt = q.cnt - (AW+1)'(1);
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// ---- rtl/spx_pkg.sv ----
/*
  Constants, reset values and shared types of the serial peripheral port.
  Assumes a single system clock; all pins are sampled by that clock.
*/
// Function
// - Master drives master-to-slave line; slave only listens; bytes go MSB first.
// - As master, the master-to-slave line always shows the shift register MSB.
// - Slave-to-master pin floats when disabled or as an unselected 4-wire slave.
// - As a 3-wire slave, the slave-to-master pin always shows the MSB.
// - Master makes the serial clock; unselected 4-wire slave ignores its edges.
// - Select mode 00 is 3-wire; a slave is always selected and must be alone.
// - Select mode 01 makes select an input: selects slave, faults a master.
// - Upper select mode bit set drives select pin with the lower mode bit.
// - Select reaches a pin in every mode except the 3-wire mode 00.
// - Select mode resets to 01, the 4-wire slave or multi-master setting.
// - Master enable with port enable makes the port master; the master starts every transfer.
// - Master data write fills the transmit buffer; empty shifter starts a byte.
// - A started master transfer shifts out at once while clocking the bus.
// - The slave shifts its own byte back at the same time, full duplex.
// - Incoming bits enter MSB first; a full byte moves to the receive buffer.
// - Each byte end sets the complete flag and requests an enabled interrupt.
// - Select low in multi-master mode clears both enables and sets mode fault.
// - Mode fault requests an enabled interrupt; port stays off until re-enabled.
package spx_pkg;

  // ==========================================================================
  // Widths and counts
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned FIFO_DEPTH  = 16;
  localparam int unsigned DIV_W       = 8;
  localparam logic [3:0]  LAST_EDGE   = 4'hf;

  // ==========================================================================
  // Select pin modes
  localparam logic [1:0]  SEL_3WIRE   = 2'h0;
  localparam logic [1:0]  SEL_4W_IN   = 2'h1;

  // ==========================================================================
  // Reset values
  localparam logic [1:0]  RST_SEL_MODE  = 2'h1;
  localparam logic        RST_MASTER_EN = 1'h0;
  localparam logic        RST_PORT_EN   = 1'h0;
  localparam logic        RST_CLK_POL   = 1'h0;
  localparam logic        RST_CLK_PHA   = 1'h0;
  localparam logic [7:0]  RST_CLK_DIV   = 8'h03;

  // ==========================================================================
  // Synchroniser lanes and their idle levels
  localparam int unsigned PIN_MISO = 0;
  localparam int unsigned PIN_MOSI = 1;
  localparam int unsigned PIN_SCK  = 2;
  localparam int unsigned PIN_NSS  = 3;
  localparam int unsigned PIN_W    = 4;
  localparam logic [3:0]  SYNC_RST = 4'h8;

  // ==========================================================================
  // Transfer states and one-edge result
  typedef enum logic [2:0] {
    SPX_IDLE   = 3'h1,
    SPX_MASTER = 3'h2,
    SPX_SLAVE  = 3'h4
  } spx_state_t;

  typedef struct packed {
    logic [BYTE_W-1:0] shreg;
    logic              samp;
    logic              last;
  } spx_step_t;

endpackage

// ---- rtl/spx_port.sv ----
/*
  Serial peripheral port: master and slave byte exchange, pin roles,
  select pin modes, mode fault, transmit FIFO and receive buffer.
  Assumes all pin inputs are asynchronous and software uses the plain
  control ports below on the system clock.
*/
module spx_port (
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      reset,
  // Control write
  input  wire logic                      ctrl_wr,
  input  wire logic                      ctrl_master_enable,
  input  wire logic                      ctrl_port_enable,
  input  wire logic [1:0]                ctrl_select_mode,
  input  wire logic                      ctrl_clk_pol,
  input  wire logic                      ctrl_clk_pha,
  input  wire logic [spx_pkg::DIV_W-1:0] ctrl_clk_div,
  // Flag clears and interrupt enable
  input  wire logic                      clear_complete,
  input  wire logic                      clear_fault,
  input  wire logic                      irq_enable,
  // Control and status
  output wire logic                      master_enable_bit,
  output wire logic                      port_enable_bit,
  output wire logic [1:0]                select_pin_mode_field,
  output wire logic                      transfer_complete_flag,
  output wire logic                      mode_fault_flag,
  output wire logic                      busy,
  output wire logic                      irq,
  // Transmit data
  input  wire logic                      tx_valid,
  input  wire logic [spx_pkg::BYTE_W-1:0] tx_data,
  output wire logic                      tx_ready,
  // Receive buffer
  output wire logic [spx_pkg::BYTE_W-1:0] rx_data,
  output wire logic                      rx_valid,
  input  wire logic                      rx_read,
  // Serial clock pin
  input  wire logic                      sck_in,
  output wire logic                      sck_out,
  output wire logic                      sck_oe,
  // Master-to-slave data pin
  input  wire logic                      mosi_in,
  output wire logic                      mosi_out,
  output wire logic                      mosi_oe,
  // Slave-to-master data pin
  input  wire logic                      miso_in,
  output wire logic                      miso_out,
  output wire logic                      miso_oe,
  // Select pin
  input  wire logic                      slave_select_pin_in,
  output wire logic                      slave_select_pin_out,
  output wire logic                      slave_select_pin_oe,
  output wire logic                      slave_select_routed
);
  import spx_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    spx_state_t        state;
    logic              master_en;
    logic              port_en;
    logic [1:0]        sel_mode;
    logic              clk_pol;
    logic              clk_pha;
    logic [DIV_W-1:0]  clk_div;
    logic [DIV_W-1:0]  div_cnt;
    logic [BYTE_W-1:0] shreg;
    logic              sr_full;
    logic              samp;
    logic [3:0]        edge_k;
    logic              sck;
    logic              sck_prev;
    logic              nss_prev;
    logic              complete;
    logic              fault;
    logic [BYTE_W-1:0] rx_data;
    logic              rx_valid;
  } spx_core_st_t;

  localparam spx_core_st_t CORE_RST = '{
    state:     SPX_IDLE,
    master_en: RST_MASTER_EN,
    port_en:   RST_PORT_EN,
    sel_mode:  RST_SEL_MODE,
    clk_pol:   RST_CLK_POL,
    clk_pha:   RST_CLK_PHA,
    clk_div:   RST_CLK_DIV,
    div_cnt:   RST_CLK_DIV,
    shreg:     '0,
    sr_full:   1'h0,
    samp:      1'h0,
    edge_k:    4'h0,
    sck:       RST_CLK_POL,
    sck_prev:  RST_CLK_POL,
    nss_prev:  1'h1,
    complete:  1'h0,
    fault:     1'h0,
    rx_data:   '0,
    rx_valid:  1'h0
  };

  spx_core_st_t q;
  spx_core_st_t d;

  // ==========================================================================
  // Pin synchronisers: every pin level passes two flops first
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_s;
  logic             miso_s;
  logic             mosi_s;
  logic             sck_s;
  logic             nss_s;

  assign pins_raw[PIN_MISO] = miso_in;
  assign pins_raw[PIN_MOSI] = mosi_in;
  assign pins_raw[PIN_SCK]  = sck_in;
  assign pins_raw[PIN_NSS]  = slave_select_pin_in;

  spx_sync #(
    .W   (PIN_W),
    .RST (SYNC_RST)
  ) u_sync (
    .clock (clock),
    .reset (reset),
    .din   (pins_raw),
    .dout  (pins_s)
  );

  assign miso_s = pins_s[PIN_MISO];
  assign mosi_s = pins_s[PIN_MOSI];
  assign sck_s  = pins_s[PIN_SCK];
  assign nss_s  = pins_s[PIN_NSS];

  // ==========================================================================
  // Transmit FIFO; its ready is the write side's back-pressure
  spx_stream_if #(.WIDTH(BYTE_W)) wr_if ();
  spx_stream_if #(.WIDTH(BYTE_W)) rd_if ();

  assign wr_if.valid = tx_valid;
  assign wr_if.data  = tx_data;
  assign tx_ready    = wr_if.ready;

  spx_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock (clock),
    .reset (reset),
    .push  (wr_if),
    .pop   (rd_if)
  );

  // ==========================================================================
  // One serial clock edge of a byte, shared by master and slave.
  // Even edge indices are leading edges; phase picks the sampling edge.
  function automatic spx_step_t spx_edge_step(
    input logic [BYTE_W-1:0] shreg,
    input logic              samp,
    input logic [3:0]        k,
    input logic              pha,
    input logic              bit_in
  );
    spx_step_t r;
    logic      sample_edge;
    r.shreg     = shreg;
    r.samp      = samp;
    r.last      = (k == LAST_EDGE);
    sample_edge = (~k[0]) ^ pha;
    if (sample_edge) begin
      r.samp = bit_in;
    end
    // Phase 1 keeps the MSB across the first leading edge
    if ((!sample_edge && !(pha && (k == 4'h0))) || r.last) begin
      r.shreg = {shreg[BYTE_W-2:0], (r.last && pha) ? bit_in : samp};
    end
    return r;
  endfunction

  // ==========================================================================
  // Decodes
  logic      is_master;
  logic      selected;
  logic      fault_now;
  logic      tick;
  logic      slave_edge;
  logic      edge_ev;
  logic      bit_in;
  logic      pop_now;
  spx_step_t step;

  assign is_master = q.master_en && q.port_en;
  // Mode 00 slave is always selected, mode 01 by a low pin
  assign selected  = (q.sel_mode == SEL_3WIRE) ||
                     ((q.sel_mode == SEL_4W_IN) && !nss_s);
  // Low select in multi-master mode; a falling edge always lands here too
  assign fault_now = is_master && (q.sel_mode == SEL_4W_IN) &&
                     !nss_s;
  assign tick       = (q.state == SPX_MASTER) && (q.div_cnt == '0);
  // Slave edges count only while selected
  assign slave_edge = (q.state == SPX_SLAVE) && selected &&
                      (sck_s != q.sck_prev);
  assign edge_ev    = tick || slave_edge;
  // Master listens on the slave line, slave on the master line
  assign bit_in     = (q.state == SPX_MASTER) ? miso_s : mosi_s;
  assign step       = spx_edge_step(q.shreg, q.samp, q.edge_k, q.clk_pha,
                                    bit_in);

  // Pop into an empty shifter: master starts a byte, slave preloads
  assign pop_now = rd_if.valid && !q.sr_full && !fault_now &&
                   (((q.state == SPX_IDLE) && is_master) ||
                    ((q.state == SPX_SLAVE) && !edge_ev &&
                     (q.edge_k == 4'h0)));
  assign rd_if.ready = pop_now;

  // ==========================================================================
  // Next state
  always_comb begin
    d          = q;
    d.sck_prev = sck_s;
    d.nss_prev = nss_s;

    // Software control write
    if (ctrl_wr) begin
      d.master_en = ctrl_master_enable;
      d.port_en   = ctrl_port_enable;
      d.sel_mode  = ctrl_select_mode;
      d.clk_pol   = ctrl_clk_pol;
      d.clk_pha   = ctrl_clk_pha;
      d.clk_div   = ctrl_clk_div;
    end

    // Clears first so a same-cycle set below wins
    if (clear_complete) begin
      d.complete = 1'h0;
    end
    if (clear_fault) begin
      d.fault = 1'h0;
    end
    if (rx_read) begin
      d.rx_valid = 1'h0;
    end

    unique case (q.state)
      SPX_IDLE: begin
        d.sck    = q.clk_pol;
        d.edge_k = 4'h0;
        if (q.port_en && !q.master_en) begin
          d.state = SPX_SLAVE;
        end
      end
      SPX_MASTER: begin
        // Half-period divider generates the bus clock
        if (tick) begin
          d.sck     = ~q.sck;
          d.div_cnt = q.clk_div;
        end else begin
          d.div_cnt = q.div_cnt - DIV_W'(1);
        end
        if (!is_master) begin
          d.state = SPX_IDLE;
        end
      end
      SPX_SLAVE: begin
        // Falling select restarts the byte in 4-wire slave mode
        if ((q.sel_mode == SEL_4W_IN) && q.nss_prev && !nss_s) begin
          d.edge_k = 4'h0;
        end
        if (!q.port_en || q.master_en) begin
          d.state = SPX_IDLE;
        end
      end
    endcase

    // Sample or shift on each edge; the sixteenth closes the byte
    if (edge_ev) begin
      d.shreg  = step.shreg;
      d.samp   = step.samp;
      d.edge_k = q.edge_k + 4'h1;
      if (step.last) begin
        d.edge_k   = 4'h0;
        d.sr_full  = 1'h0;
        d.complete = 1'h1;
        d.rx_data  = step.shreg;
        d.rx_valid = 1'h1;
        if (q.state == SPX_MASTER) begin
          d.state = SPX_IDLE;
        end
      end
    end

    // Load the shifter from the transmit buffer
    if (pop_now) begin
      d.shreg   = rd_if.data;
      d.sr_full = 1'h1;
      if (q.state == SPX_IDLE) begin
        d.state   = SPX_MASTER;
        d.div_cnt = q.clk_div;
        d.sck     = q.clk_pol;
        d.edge_k  = 4'h0;
      end
    end

    // Disabling the port also resets the bit counter
    if (!q.port_en) begin
      d.edge_k = 4'h0;
    end

    // Mode fault beats a same-cycle software write of the enables
    if (fault_now) begin
      d.master_en = 1'h0;
      d.port_en   = 1'h0;
      d.fault     = 1'h1;
      d.state     = SPX_IDLE;
      d.edge_k    = 4'h0;
      d.sr_full   = 1'h0;
      d.sck       = q.clk_pol;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      q <= CORE_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Pin roles
  assign sck_oe   = is_master;
  assign sck_out  = q.sck;
  assign mosi_oe  = is_master;
  assign mosi_out = q.shreg[BYTE_W-1];
  // Floats when off or as an unselected 4-wire slave
  assign miso_oe  = q.port_en && !q.master_en && selected;
  assign miso_out = q.shreg[BYTE_W-1];
  // Upper mode bit turns select into an output carrying the lower bit
  assign slave_select_pin_oe  = q.sel_mode[1];
  assign slave_select_pin_out = q.sel_mode[0];
  assign slave_select_routed  = (q.sel_mode != SEL_3WIRE);

  // ==========================================================================
  // Status and interrupt request
  assign master_enable_bit      = q.master_en;
  assign port_enable_bit        = q.port_en;
  assign select_pin_mode_field  = q.sel_mode;
  assign transfer_complete_flag = q.complete;
  assign mode_fault_flag        = q.fault;
  assign busy                   = (q.state == SPX_MASTER);
  assign irq = irq_enable && (q.complete || q.fault);
  assign rx_data  = q.rx_data;
  assign rx_valid = q.rx_valid;
endmodule

// ---- rtl/spx_stream_if.sv ----
/*
  Valid/ready word stream between the port's own modules.
  Assumes both ends run on the same clock.
*/
interface spx_stream_if #(
  parameter int unsigned WIDTH = 8
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- rtl/spx_sync.sv ----
/*
  Two-flop synchroniser for a group of asynchronous pin levels.
  Assumes each lane is a slow level; no lane is read before the second flop.
*/
module spx_sync #(
  parameter int unsigned   W   = 4,
  parameter logic [W-1:0]  RST = '0
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         reset,
  // Levels
  input  wire logic [W-1:0] din,
  output wire logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } spx_sync_st_t;

  spx_sync_st_t q;
  spx_sync_st_t d;

  // ==========================================================================
  // Stages
  always_comb begin
    d.meta = din;
    d.sync = q.meta;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      q <= {RST, RST};
    end else begin
      q <= d;
    end
  end

  assign dout = q.sync;
endmodule

// ---- tb/spx_port_assertions.sv ----
/*
  Concurrent checks on the serial port's top-level ports, bound into it.
  Assumes one system clock domain and an active-high async reset.
*/
module spx_port_assertions (
  // Clock and reset
  input wire logic       clock,
  input wire logic       reset,
  // Control and status
  input wire logic       ctrl_wr,
  input wire logic       irq_enable,
  input wire logic       master_enable_bit,
  input wire logic       port_enable_bit,
  input wire logic [1:0] select_pin_mode_field,
  input wire logic       transfer_complete_flag,
  input wire logic       mode_fault_flag,
  input wire logic       irq,
  // Pins
  input wire logic       sck_oe,
  input wire logic       mosi_oe,
  input wire logic       miso_oe,
  input wire logic       slave_select_pin_in,
  input wire logic       slave_select_pin_out,
  input wire logic       slave_select_pin_oe,
  input wire logic       slave_select_routed
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Pin roles and select modes
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  master_drive_a: assert property (mosi_oe |-> master_enable_bit
    && port_enable_bit) else $error("data out driven while not master");
  clock_drive_a: assert property (sck_oe |-> master_enable_bit)
    else $error("serial clock driven while not master");
  miso_float_a: assert property (!port_enable_bit |-> !miso_oe)
    else $error("slave data out driven while disabled");
  sel_output_a: assert property (select_pin_mode_field[1] |->
    slave_select_pin_oe && slave_select_pin_out == select_pin_mode_field[0])
    else $error("select output does not follow mode");
  sel_routed_a: assert property (slave_select_routed ==
    (select_pin_mode_field != 2'h0)) else $error("select routing wrong");
  // Sync delay of two flops leaves two more cycles for the fault
  fault_raise_a: assert property ((master_enable_bit && port_enable_bit
    && select_pin_mode_field == 2'h1 && !slave_select_pin_in) [*3]
    |-> ##[0:2] mode_fault_flag) else $error("mode fault not raised");
  stay_off_a: assert property (!port_enable_bit && !ctrl_wr
    |=> !port_enable_bit) else $error("port enabled itself");
  irq_flags_a: assert property (irq == (irq_enable &&
    (transfer_complete_flag || mode_fault_flag)))
    else $error("interrupt request does not match flags");
endmodule

bind spx_port spx_port_assertions spx_port_assertions_inst (
  .clock(clock), .reset(reset), .ctrl_wr(ctrl_wr),
  .irq_enable(irq_enable), .master_enable_bit(master_enable_bit),
  .port_enable_bit(port_enable_bit),
  .select_pin_mode_field(select_pin_mode_field),
  .transfer_complete_flag(transfer_complete_flag),
  .mode_fault_flag(mode_fault_flag), .irq(irq), .sck_oe(sck_oe),
  .mosi_oe(mosi_oe), .miso_oe(miso_oe),
  .slave_select_pin_in(slave_select_pin_in),
  .slave_select_pin_out(slave_select_pin_out),
  .slave_select_pin_oe(slave_select_pin_oe),
  .slave_select_routed(slave_select_routed)
);

// ---- tb/spx_port_test.sv ----
/*
  Self-checking bench for the serial port with a slave model.
  Assumes the package and design files are compiled first.
*/
module spx_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, reset = 1'b1, ctrl_wr = 1'b0, c_m = 1'b0;
  logic c_p = 1'b0, clr_c = 1'b0, clr_f = 1'b0, ien = 1'b0, c_pol = 1'b0;
  logic tx_valid = 1'b0, rx_read = 1'b0, tb_sck = 1'b0, tb_mosi = 1'b0;
  logic tb_ss = 1'b1, mdl_sel_n = 1'b1;
  logic [1:0] c_mode = 2'h1;
  logic [7:0] tx_data = 8'h00, mdl_load = 8'h00;
  wire logic m_en, p_en, cflag, fflag, busy, irq, tx_ready, rx_valid;
  wire logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  wire logic ss_o, ss_oe, routed, mdl_miso;
  wire logic [1:0] mode_f;
  wire logic [7:0] rx_data, mdl_got;
  // Each wire resolves from whoever enables its driver
  wire logic sck_l = sck_oe ? sck_o : tb_sck;
  wire logic mosi_l = mosi_oe ? mosi_o : tb_mosi;
  wire logic miso_l = miso_oe ? miso_o : mdl_miso;
  wire logic ss_l = ss_oe ? ss_o : tb_ss;
  int bad_count = 0, cmp_count = 0, cyc = 0;

  spx_port spx_port_inst (.clock(clock), .reset(reset), .ctrl_wr(ctrl_wr),
    .ctrl_master_enable(c_m), .ctrl_port_enable(c_p),
    .ctrl_select_mode(c_mode), .ctrl_clk_pol(c_pol), .ctrl_clk_pha(1'b0),
    .ctrl_clk_div(8'h03), .clear_complete(clr_c), .clear_fault(clr_f),
    .irq_enable(ien), .master_enable_bit(m_en), .port_enable_bit(p_en),
    .select_pin_mode_field(mode_f), .transfer_complete_flag(cflag),
    .mode_fault_flag(fflag), .busy(busy), .irq(irq), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_read(rx_read), .sck_in(sck_l),
    .sck_out(sck_o), .sck_oe(sck_oe), .mosi_in(mosi_l), .mosi_out(mosi_o),
    .mosi_oe(mosi_oe), .miso_in(miso_l), .miso_out(miso_o),
    .miso_oe(miso_oe), .slave_select_pin_in(ss_l),
    .slave_select_pin_out(ss_o), .slave_select_pin_oe(ss_oe),
    .slave_select_routed(routed));
  spx_slave_model spx_slave_model_inst (.sck(sck_l), .mosi(mosi_l),
    .sel_n(mdl_sel_n), .miso(mdl_miso), .load(mdl_load), .got(mdl_got));

  // ==========================================================================
  // Clock, timeout and shared tasks
  always #10 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clock);
  endtask
  // Control write, then settle to the falling edge for checks
  task automatic wr(logic m, logic p, logic [1:0] md);
    @(posedge clock);
    c_m <= m; c_p <= p; c_mode <= md; ctrl_wr <= 1'b1;
    @(posedge clock);
    ctrl_wr <= 1'b0;
    @(posedge clock);
    @(negedge clock);
  endtask
  task automatic push(logic [7:0] b);
    @(posedge clock);
    tx_valid <= 1'b1; tx_data <= b;
    @(posedge clock);
    tx_valid <= 1'b0;
  endtask

  // ==========================================================================
  // Scenarios
  // Fill the buffer while disabled, then drain as 3-wire master
  task automatic t_master;
    logic [7:0] prev;
    @(posedge clock);
    mdl_load <= 8'hc3; mdl_sel_n <= 1'b0; ien <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      @(posedge clock);
      tx_valid <= 1'b1; tx_data <= 8'(i * 17);
    end
    @(posedge clock);
    tx_valid <= 1'b0;
    @(negedge clock);
    chk("tx_ready full", tx_ready, 1'b0);
    wr(1'b1, 1'b1, 2'h0);
    prev = 8'hc3;
    for (int i = 0; i < 16; i++) begin
      for (int k = 0; k < 200 && cflag !== 1'b1; k++) @(negedge clock);
      chk("rx_data", rx_data, prev);
      chk("irq", irq, 1'b1);
      @(posedge clock);
      clr_c <= 1'b1; rx_read <= 1'b1;
      @(posedge clock);
      clr_c <= 1'b0; rx_read <= 1'b0;
      @(negedge clock);
      chk("complete clear", cflag, 1'b0);
      prev = 8'(i * 17);
    end
    chk("slave got", mdl_got, 8'hff);
  endtask
  task automatic t_select;
    wr(1'b1, 1'b1, 2'h2);
    chk("ss_oe", ss_oe, 1'b1);
    chk("ss_out low", ss_o, 1'b0);
    chk("routed", routed, 1'b1);
    @(posedge clock);
    c_pol <= 1'b1;
    wr(1'b1, 1'b1, 2'h3);
    chk("ss_out high", ss_o, 1'b1);
    chk("sck idle high", sck_o, 1'b1);
    @(posedge clock);
    c_pol <= 1'b0;
    wr(1'b1, 1'b1, 2'h0);
    chk("unrouted", routed, 1'b0);
  endtask
  // Another master pulls select low in mid-byte
  task automatic t_fault;
    @(posedge clock);
    mdl_sel_n <= 1'b1;
    wr(1'b1, 1'b1, 2'h1);
    push(8'h81);
    for (int k = 0; k < 20 && busy !== 1'b1; k++) @(negedge clock);
    chk("busy", busy, 1'b1);
    chk("mosi msb", mosi_o, 1'b1);
    chk("sck_oe", sck_oe, 1'b1);
    @(posedge clock);
    tb_ss <= 1'b0;
    for (int k = 0; k < 10 && fflag !== 1'b1; k++) @(negedge clock);
    chk("fault", fflag, 1'b1);
    chk("master off", m_en, 1'b0);
    chk("port off", p_en, 1'b0);
    tick(20);
    @(negedge clock);
    chk("still off", p_en, 1'b0);
    chk("fault irq", irq, 1'b1);
    chk("idle", busy, 1'b0);
    @(posedge clock);
    clr_f <= 1'b1; tb_ss <= 1'b1;
    @(posedge clock);
    clr_f <= 1'b0;
    @(negedge clock);
    chk("fault clear", fflag, 1'b0);
  endtask
  // Bench is master at 160 ns; a high select leaves a 4-wire slave idle
  task automatic t_slave(logic [1:0] md, logic [7:0] mo, logic [7:0] exp);
    logic [7:0] got;
    logic       sel;
    push(8'h96);
    sel = (md == 2'h0) || !tb_ss;
    wr(1'b0, 1'b1, md);
    tick(4);
    for (int b = 7; b >= 0; b--) begin
      @(posedge clock);
      tb_mosi <= mo[b];
      tick(2);
      @(negedge clock);
      got = {got[6:0], miso_l};
      @(posedge clock);
      tb_sck <= 1'b1;
      tick(3);
      @(posedge clock);
      tb_sck <= 1'b0;
    end
    tick(6);
    @(negedge clock);
    chk("complete", cflag, sel);
    if (sel) chk("miso bits", got, 8'h96);
    chk("rx byte", rx_data, exp);
  endtask

  initial begin
    tick(12);
    reset <= 1'b0;
    @(negedge clock);
    chk("mode reset", mode_f, 2'h1);
    chk("routed reset", routed, 1'b1);
    chk("miso reset", miso_oe, 1'b0);
    t_master();
    t_select();
    t_fault();
    t_slave(2'h0, 8'h69, 8'h69);
    @(posedge clock);
    clr_c <= 1'b1; rx_read <= 1'b1;
    @(posedge clock);
    clr_c <= 1'b0; rx_read <= 1'b0;
    t_slave(2'h1, 8'h3c, 8'h69);
    chk("unselected miso", miso_oe, 1'b0);
    @(posedge clock);
    tb_ss <= 1'b0;
    t_slave(2'h1, 8'h5a, 8'h5a);
    end_sim();
  end
endmodule

// ---- tb/spx_slave_model.sv ----
/*
  Behavioural serial slave, idle-low clock, sample on leading edge.
  Assumes the bench drives its select and preload byte.
*/
module spx_slave_model (
  // Pins
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  output logic            miso,
  // Byte side
  input  wire logic [7:0] load,
  output logic [7:0]      got
);
  timeunit 1ns;
  timeprecision 1ns;
  logic bit_q = 1'b0;
  logic last = 1'b0;
  initial got = 8'h00;
  // ==========================================================================
  // Shift register exchange
  always @(negedge sel_n) got = load;
  always @(posedge sck) if (!sel_n) bit_q = mosi;
  always @(negedge sck) if (!sel_n) got = {got[6:0], bit_q};
  // Released line shows the inverse, so a stale bit never passes
  always @(got[7] or sel_n) if (!sel_n) last = got[7];
  assign miso = sel_n ? ~last : got[7];
endmodule
